//--- rtl/bslc_pkg.sv
// shared constants and types for the burner sequence lockout controller
package bslc_pkg;
	// clock and derived cycle counts
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned TICK_S = 1;
	localparam int unsigned TICK_CYCLES = CLK_HZ * TICK_S;
	localparam int unsigned HOLD_S = 3;
	localparam int unsigned HOLD_CYCLES = CLK_HZ * HOLD_S;
	// sequence durations in seconds
	localparam int SEC_W = 10;
	localparam logic [9:0] PREPURGE_S = 10'h023;
	localparam logic [9:0] AIR_WAIT_S = 10'h12c;
	localparam logic [9:0] IGN_DELAY_S = 10'h002;
	localparam logic [9:0] IGN_STD_S = 10'h003;
	localparam logic [9:0] IGN_RETRY_S = 10'h00a;
	localparam logic [9:0] PILOT_STD_S = 10'h005;
	localparam logic [9:0] PILOT_RETRY_S = 10'h00a;
	localparam logic [9:0] MAIN_S = 10'h003;
	localparam logic [9:0] MAIN_DMI_S = 10'h000;
	localparam logic [9:0] SAFETY_S = 10'h014;
	localparam logic [9:0] BLINK_S = 10'h002;
	localparam logic [9:0] REMOTE_WIN_S = 10'h384;
	localparam int REMOTE_MAX = 5;
	// register port
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	localparam logic [3:0] ADDR_TIMER = 4'h8;
	localparam logic CTRL_RETRY_RST = 1'h0;
	localparam int CTRL_RETRY_BIT = 0;
	localparam int ST_STATE_LSB = 0;
	localparam int ST_LOCK_BIT = 4;
	localparam int ST_ALARM_BIT = 5;
	localparam int ST_FLOSS_BIT = 6;
	localparam int ST_RCNT_LSB = 8;
	// synchronised input positions
	localparam int IN_DEMAND = 0;
	localparam int IN_AIR = 1;
	localparam int IN_FLAME = 2;
	localparam int IN_ILOCK = 3;
	localparam int IN_DMI = 4;
	localparam int IN_RST_LOC = 5;
	localparam int IN_RST_REM = 6;
	localparam int IN_RESTORE = 7;
	localparam int N_IN = 8;
	// sequence states, gray coded along the normal path
	typedef enum logic [3:0] {
		ST_POWERUP = 4'h0,
		ST_STANDBY = 4'h1,
		ST_WAIT_AIR = 4'h3,
		ST_PREPURGE = 4'h2,
		ST_IGN_DELAY = 4'h6,
		ST_IGN_TRIAL = 4'h7,
		ST_PILOT_ONLY = 4'h5,
		ST_MAIN_TRIAL = 4'h4,
		ST_RUN = 4'hc,
		ST_SAFETY = 4'hd,
		ST_LOCKOUT = 4'hf,
		ST_WIND_DOWN = 4'he
	} bslc_state_t;
endpackage : bslc_pkg

//--- rtl/bslc_tick.sv
// one second tick and blink phase derived from the system clock
`timescale 1ns/1ns
module bslc_tick #(
	parameter int unsigned CYCLES = bslc_pkg::TICK_CYCLES
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic restart_i,
	output logic tick_o,
	output logic blink_o
);
	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;
	logic tick_d;
	logic blink_d;

	// divider restarted at each phase entry so a phase never runs short, pulse at wrap
	always_comb
	begin
		tick_d = (cnt_q == LAST) && !restart_i;
		cnt_d = (tick_d || restart_i) ? '0 : cnt_q + CW'(1);
		blink_d = tick_d ? ~blink_o : blink_o;
	end

	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			cnt_q <= '0;
			tick_o <= 1'b0;
			blink_o <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_d;
			tick_o <= tick_d;
			blink_o <= blink_d;
		end
	end
endmodule : bslc_tick

//--- rtl/bslc_nvstore.sv
// lockout flag mirrored to external non-volatile storage
`timescale 1ns/1ns
module bslc_nvstore (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic restore_i,
	input wire logic set_i,
	input wire logic clr_i,
	output logic locked_o,
	output logic ready_o
);
	// restore input reaches this block through a two-stage synchroniser
	localparam logic [1:0] LOAD_LAST = 2'h2;
	logic locked_d;
	logic [1:0] load_q;
	logic [1:0] load_d;

	// restored value tracked until the synchroniser has filled; set beats clear
	always_comb
	begin
		load_d = (load_q == LOAD_LAST) ? load_q : load_q + 2'h1;
		if (!ready_o)
			locked_d = restore_i | set_i;
		else if (set_i)
			locked_d = 1'b1;
		else if (clr_i)
			locked_d = 1'b0;
		else
			locked_d = locked_o;
	end

	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			locked_o <= 1'b0;
			ready_o <= 1'b0;
			load_q <= 2'h0;
		end
		else
		begin
			locked_o <= locked_d;
			ready_o <= (load_q == LOAD_LAST);
			load_q <= load_d;
		end
	end
endmodule : bslc_nvstore

//--- rtl/bslc_top.sv
// burner sequencing, flame supervision and safety lockout controller
//
// Added by the designer: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
// Behaviour
// RULE1 - pre-purge lasts 35 s, parameter only
// RULE2 - direct main ignition makes main trial zero
// RULE3 - flame loss locks out at once, no recycle
// RULE4 - air switch opening shuts down in sequence
// RULE5 - flame in standby or pre-purge shuts down
// RULE6 - no flame at trial end shuts down
// RULE7 - retry model retries once, 10 s times
// RULE8 - reset needs 3 s hold, clears alarm
// RULE9 - after reset restart, or lock again if faulty
// RULE10 - lockout survives power loss
// RULE11 - remote reset at most 5 per 15 min
// RULE12 - 20 s lockout timing ignores resets
// RULE13 - alarm and fault LED set at shutdown
// RULE14 - blink LEDs at power-up, then await demand
// RULE15 - run flame loss blinks both LEDs
// RULE16 - 2 s ignition delay after pre-purge
// RULE17 - direct main ignition goes straight to run
// RULE18 - open interlock locks out in any state; the check is skipped in the power-up, safety and lockout states
// RULE19 - start only with no flame, air open, interlock closed
// RULE20 - standard times 3/5/3 s, 300 s air wait
// RULE21 - phase timers count seconds from entry
module bslc_top #(
	parameter int unsigned TICK_CYCLES = bslc_pkg::TICK_CYCLES,
	parameter int unsigned HOLD_CYCLES = bslc_pkg::HOLD_CYCLES,
	parameter logic [9:0] PREPURGE_S = bslc_pkg::PREPURGE_S
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic heat_demand_i,
	input wire logic air_flow_proving_switch_i,
	input wire logic flame_i,
	input wire logic interlock_closed_i,
	input wire logic direct_main_ignition_i,
	input wire logic reset_local_i,
	input wire logic reset_remote_i,
	input wire logic lock_restore_i,
	input wire logic [bslc_pkg::ADDR_W-1:0] addr_i,
	input wire logic [bslc_pkg::DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [bslc_pkg::DATA_W-1:0] rdata_o,
	output logic blower_o,
	output logic igniter_o,
	output logic pilot_intermittent_o,
	output logic pilot_interrupted_o,
	output logic main_valve_o,
	output logic alarm_o,
	output logic led_flame_o,
	output logic led_alarm_o,
	output logic lock_store_o
);
	localparam int HW = $clog2(HOLD_CYCLES + 1);
	localparam logic [HW-1:0] HOLD_LAST = HW'(HOLD_CYCLES);
	localparam int SW = bslc_pkg::SEC_W;
	localparam int RM = bslc_pkg::REMOTE_MAX;

	logic [bslc_pkg::N_IN-1:0] in_meta_q;
	logic [bslc_pkg::N_IN-1:0] in_q;
	logic tick;
	logic blink;
	logic nv_locked;
	logic nv_ready;
	logic nv_set;
	logic nv_clr;
	bslc_pkg::bslc_state_t state_q;
	bslc_pkg::bslc_state_t state_d;
	logic [SW-1:0] sec_q;
	logic [SW-1:0] sec_d;
	logic retry_used_q;
	logic retry_used_d;
	logic floss_q;
	logic floss_d;
	logic alarm_d;
	logic retry_en_q;
	logic retry_en_d;
	logic [HW-1:0] hold_loc_q;
	logic [HW-1:0] hold_loc_d;
	logic [HW-1:0] hold_rem_q;
	logic [HW-1:0] hold_rem_d;
	logic [SW-1:0] slot_q [RM];
	logic [SW-1:0] slot_d [RM];
	logic [2:0] rem_used;
	logic rst_ok;
	logic rem_ok;
	logic fault;
	logic [bslc_pkg::DATA_W-1:0] rdata_d;
	logic blower_d;
	logic igniter_d;
	logic pil_int_d;
	logic pil_intr_d;
	logic main_d;
	logic led_flame_d;
	logic led_alarm_d;

	// phase duration lookups per model variant
	function automatic logic [SW-1:0] ign_time(input logic retry);
		return retry ? bslc_pkg::IGN_RETRY_S : bslc_pkg::IGN_STD_S;
	endfunction : ign_time

	function automatic logic [SW-1:0] pilot_time(input logic retry);
		return retry ? bslc_pkg::PILOT_RETRY_S : bslc_pkg::PILOT_STD_S;
	endfunction : pilot_time

	function automatic logic in_sequence(input bslc_pkg::bslc_state_t s);
		return (s == bslc_pkg::ST_PREPURGE) || (s == bslc_pkg::ST_IGN_DELAY) ||
			(s == bslc_pkg::ST_IGN_TRIAL) || (s == bslc_pkg::ST_PILOT_ONLY) ||
			(s == bslc_pkg::ST_MAIN_TRIAL) || (s == bslc_pkg::ST_RUN);
	endfunction : in_sequence

	// two-stage synchroniser for all field inputs
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			in_meta_q <= '0;
			in_q <= '0;
		end
		else
		begin
			in_meta_q <= {lock_restore_i, reset_remote_i, reset_local_i,
				direct_main_ignition_i, interlock_closed_i, flame_i,
				air_flow_proving_switch_i, heat_demand_i};
			in_q <= in_meta_q;
		end
	end

	bslc_tick #(
		.CYCLES(TICK_CYCLES)
	) u_tick (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.restart_i(state_d != state_q), // RULE21
		.tick_o(tick),
		.blink_o(blink)
	);

	bslc_nvstore u_nv (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.restore_i(in_q[bslc_pkg::IN_RESTORE]),
		.set_i(nv_set),
		.clr_i(nv_clr),
		.locked_o(nv_locked),
		.ready_o(nv_ready)
	);

	// reset buttons: hold timing only counts during lockout
	always_comb
	begin
		hold_loc_d = '0;
		hold_rem_d = '0;
		if (state_q == bslc_pkg::ST_LOCKOUT)
		begin
			if (in_q[bslc_pkg::IN_RST_LOC] && hold_loc_q != HOLD_LAST)
				hold_loc_d = hold_loc_q + HW'(1);
			else if (in_q[bslc_pkg::IN_RST_LOC])
				hold_loc_d = hold_loc_q;
			if (in_q[bslc_pkg::IN_RST_REM] && hold_rem_q != HOLD_LAST)
				hold_rem_d = hold_rem_q + HW'(1);
			else if (in_q[bslc_pkg::IN_RST_REM])
				hold_rem_d = hold_rem_q;
		end
	end

	// remote reset window: one slot per accepted remote reset
	always_comb
	begin
		rem_used = 3'h0;
		rem_ok = 1'b0;
		for (int i = 0; i < RM; i++)
		begin
			if (slot_q[i] != '0)
				rem_used = rem_used + 3'h1;
		end
		if (state_q == bslc_pkg::ST_LOCKOUT && in_q[bslc_pkg::IN_RST_REM] &&
			hold_rem_d == HOLD_LAST && hold_rem_q != HOLD_LAST &&
			rem_used < 3'(RM))
			rem_ok = 1'b1; // RULE11 RULE8
		rst_ok = rem_ok || (state_q == bslc_pkg::ST_LOCKOUT &&
			in_q[bslc_pkg::IN_RST_LOC] && hold_loc_d == HOLD_LAST &&
			hold_loc_q != HOLD_LAST); // RULE8
		for (int i = 0; i < RM; i++)
			slot_d[i] = (tick && slot_q[i] != '0) ? slot_q[i] - SW'(1) : slot_q[i];
		for (int i = 0; i < RM; i++)
		begin
			if (rem_ok && slot_q[i] == '0)
			begin
				slot_d[i] = bslc_pkg::REMOTE_WIN_S; // RULE11
				break;
			end
		end
	end

	// sequence state machine
	always_comb
	begin
		state_d = state_q;
		sec_d = (tick && sec_q != '1) ? sec_q + SW'(1) : sec_q; // RULE21
		retry_used_d = retry_used_q;
		floss_d = floss_q;
		alarm_d = alarm_o;
		fault = 1'b0;
		nv_set = 1'b0;
		nv_clr = 1'b0;
		case (state_q)
			bslc_pkg::ST_POWERUP:
			begin
				if (nv_ready && sec_q >= bslc_pkg::BLINK_S) // RULE14
				begin
					state_d = nv_locked ? bslc_pkg::ST_LOCKOUT : bslc_pkg::ST_STANDBY; // RULE10
					alarm_d = nv_locked;
				end
			end
			bslc_pkg::ST_STANDBY:
			begin
				retry_used_d = 1'b0;
				if (in_q[bslc_pkg::IN_FLAME])
					fault = 1'b1; // RULE5
				else if (in_q[bslc_pkg::IN_DEMAND] && !in_q[bslc_pkg::IN_AIR] &&
					in_q[bslc_pkg::IN_ILOCK])
					state_d = bslc_pkg::ST_WAIT_AIR; // RULE19
			end
			bslc_pkg::ST_WAIT_AIR:
			begin
				if (in_q[bslc_pkg::IN_FLAME])
					fault = 1'b1; // RULE5
				else if (!in_q[bslc_pkg::IN_DEMAND])
					state_d = bslc_pkg::ST_WIND_DOWN;
				else if (in_q[bslc_pkg::IN_AIR])
					state_d = bslc_pkg::ST_PREPURGE;
				else if (sec_q >= bslc_pkg::AIR_WAIT_S)
					fault = 1'b1; // RULE20
			end
			bslc_pkg::ST_PREPURGE:
			begin
				if (in_q[bslc_pkg::IN_FLAME])
					fault = 1'b1; // RULE5
				else if (!in_q[bslc_pkg::IN_DEMAND])
					state_d = bslc_pkg::ST_WIND_DOWN;
				else if (sec_q >= PREPURGE_S)
					state_d = bslc_pkg::ST_IGN_DELAY; // RULE1
			end
			bslc_pkg::ST_IGN_DELAY:
			begin
				if (!in_q[bslc_pkg::IN_DEMAND])
					state_d = bslc_pkg::ST_WIND_DOWN;
				else if (sec_q >= bslc_pkg::IGN_DELAY_S)
					state_d = bslc_pkg::ST_IGN_TRIAL; // RULE16
			end
			bslc_pkg::ST_IGN_TRIAL:
			begin
				if (!in_q[bslc_pkg::IN_DEMAND])
					state_d = bslc_pkg::ST_WIND_DOWN;
				else if (sec_q >= ign_time(retry_en_q)) // RULE20 RULE7
				begin
					if (in_q[bslc_pkg::IN_FLAME])
						state_d = bslc_pkg::ST_PILOT_ONLY;
					else if (retry_en_q && !retry_used_q)
					begin
						retry_used_d = 1'b1; // RULE7
						state_d = bslc_pkg::ST_PREPURGE;
					end
					else
						fault = 1'b1; // RULE6
				end
			end
			bslc_pkg::ST_PILOT_ONLY:
			begin
				if (!in_q[bslc_pkg::IN_FLAME])
					fault = 1'b1; // RULE3
				else if (!in_q[bslc_pkg::IN_DEMAND])
					state_d = bslc_pkg::ST_WIND_DOWN;
				else if (sec_q >= pilot_time(retry_en_q)) // RULE20 RULE7
					state_d = in_q[bslc_pkg::IN_DMI] ? bslc_pkg::ST_RUN :
						bslc_pkg::ST_MAIN_TRIAL; // RULE17 RULE2
			end
			bslc_pkg::ST_MAIN_TRIAL:
			begin
				if (!in_q[bslc_pkg::IN_FLAME])
					fault = 1'b1; // RULE3 RULE6
				else if (!in_q[bslc_pkg::IN_DEMAND])
					state_d = bslc_pkg::ST_WIND_DOWN;
				else if (sec_q >= (in_q[bslc_pkg::IN_DMI] ? bslc_pkg::MAIN_DMI_S :
					bslc_pkg::MAIN_S))
					state_d = bslc_pkg::ST_RUN; // RULE2 RULE20
			end
			bslc_pkg::ST_RUN:
			begin
				if (!in_q[bslc_pkg::IN_FLAME])
				begin
					fault = 1'b1; // RULE3
					floss_d = 1'b1; // RULE15
				end
				else if (!in_q[bslc_pkg::IN_DEMAND])
					state_d = bslc_pkg::ST_WIND_DOWN;
			end
			bslc_pkg::ST_WIND_DOWN:
			begin
				if (!in_q[bslc_pkg::IN_AIR])
					state_d = bslc_pkg::ST_STANDBY;
			end
			bslc_pkg::ST_SAFETY:
			begin
				if (sec_q >= bslc_pkg::SAFETY_S)
					state_d = bslc_pkg::ST_LOCKOUT; // RULE12
			end
			bslc_pkg::ST_LOCKOUT:
			begin
				if (rst_ok)
				begin
					alarm_d = 1'b0; // RULE8
					floss_d = 1'b0;
					nv_clr = 1'b1;
					if (in_q[bslc_pkg::IN_ILOCK] && !in_q[bslc_pkg::IN_FLAME])
						state_d = bslc_pkg::ST_STANDBY; // RULE9
					else
						fault = 1'b1; // RULE9
				end
			end
			default:
				state_d = bslc_pkg::ST_POWERUP;
		endcase
		if (in_sequence(state_q) && !in_q[bslc_pkg::IN_AIR])
			fault = 1'b1; // RULE4
		if (!in_q[bslc_pkg::IN_ILOCK] && state_q != bslc_pkg::ST_SAFETY &&
			state_q != bslc_pkg::ST_LOCKOUT && state_q != bslc_pkg::ST_POWERUP)
			fault = 1'b1; // RULE18
		if (fault)
		begin
			state_d = bslc_pkg::ST_SAFETY; // RULE3
			alarm_d = 1'b1; // RULE13
			nv_set = 1'b1; // RULE10
		end
		if (state_d != state_q)
			sec_d = '0; // RULE21
	end

	// load outputs and indicators follow the next state
	always_comb
	begin
		blower_d = (state_d == bslc_pkg::ST_WAIT_AIR) || in_sequence(state_d);
		igniter_d = (state_d == bslc_pkg::ST_IGN_TRIAL); // RULE16
		pil_intr_d = (state_d == bslc_pkg::ST_IGN_TRIAL) ||
			(state_d == bslc_pkg::ST_PILOT_ONLY) || (state_d == bslc_pkg::ST_MAIN_TRIAL);
		pil_int_d = pil_intr_d || (state_d == bslc_pkg::ST_RUN);
		main_d = (state_d == bslc_pkg::ST_MAIN_TRIAL) || (state_d == bslc_pkg::ST_RUN);
		if (state_d == bslc_pkg::ST_POWERUP)
		begin
			led_flame_d = blink; // RULE14
			led_alarm_d = blink;
		end
		else if (floss_d)
		begin
			led_flame_d = blink; // RULE15
			led_alarm_d = blink;
		end
		else
		begin
			led_flame_d = in_q[bslc_pkg::IN_FLAME];
			led_alarm_d = alarm_d; // RULE13
		end
	end

	// register port: control write and registered read data
	always_comb
	begin
		retry_en_d = retry_en_q;
		if (wr_i && addr_i == bslc_pkg::ADDR_CTRL)
			retry_en_d = wdata_i[bslc_pkg::CTRL_RETRY_BIT];
		rdata_d = '0;
		if (rd_i)
		begin
			case (addr_i)
				bslc_pkg::ADDR_CTRL:
					rdata_d[bslc_pkg::CTRL_RETRY_BIT] = retry_en_q;
				bslc_pkg::ADDR_STATUS:
				begin
					rdata_d[bslc_pkg::ST_STATE_LSB +: 4] = state_q;
					rdata_d[bslc_pkg::ST_LOCK_BIT] = nv_locked;
					rdata_d[bslc_pkg::ST_ALARM_BIT] = alarm_o;
					rdata_d[bslc_pkg::ST_FLOSS_BIT] = floss_q;
					rdata_d[bslc_pkg::ST_RCNT_LSB +: 3] = rem_used;
				end
				bslc_pkg::ADDR_TIMER:
					rdata_d[SW-1:0] = sec_q;
				default:
					rdata_d = '0;
			endcase
		end
	end

	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			state_q <= bslc_pkg::ST_POWERUP;
			sec_q <= '0;
			retry_used_q <= 1'b0;
			floss_q <= 1'b0;
			retry_en_q <= bslc_pkg::CTRL_RETRY_RST;
			hold_loc_q <= '0;
			hold_rem_q <= '0;
			for (int i = 0; i < RM; i++)
				slot_q[i] <= '0;
			rdata_o <= '0;
			blower_o <= 1'b0;
			igniter_o <= 1'b0;
			pilot_intermittent_o <= 1'b0;
			pilot_interrupted_o <= 1'b0;
			main_valve_o <= 1'b0;
			alarm_o <= 1'b0;
			led_flame_o <= 1'b0;
			led_alarm_o <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			sec_q <= sec_d;
			retry_used_q <= retry_used_d;
			floss_q <= floss_d;
			retry_en_q <= retry_en_d;
			hold_loc_q <= hold_loc_d;
			hold_rem_q <= hold_rem_d;
			slot_q <= slot_d;
			rdata_o <= rdata_d;
			blower_o <= blower_d;
			igniter_o <= igniter_d;
			pilot_intermittent_o <= pil_int_d;
			pilot_interrupted_o <= pil_intr_d;
			main_valve_o <= main_d;
			alarm_o <= alarm_d;
			led_flame_o <= led_flame_d;
			led_alarm_o <= led_alarm_d;
		end
	end

	assign lock_store_o = nv_locked; // RULE10
endmodule : bslc_top

//--- verification/bslc_checker.sv
// port-level assertions for the burner sequence lockout controller, bound to its top
`timescale 1ns/1ns
module bslc_checker #(
	parameter int unsigned TICK_CYCLES = 20,
	parameter int unsigned HOLD_CYCLES = 50
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic air_flow_proving_switch_i,
	input wire logic flame_i,
	input wire logic interlock_closed_i,
	input wire logic direct_main_ignition_i,
	input wire logic reset_local_i,
	input wire logic reset_remote_i,
	input wire logic blower_o,
	input wire logic igniter_o,
	input wire logic pilot_intermittent_o,
	input wire logic pilot_interrupted_o,
	input wire logic main_valve_o,
	input wire logic alarm_o,
	input wire logic led_alarm_o
);
	localparam int LED_HI = TICK_CYCLES + 2;
	localparam int MT_LO = 3 * TICK_CYCLES - 2;
	localparam int MT_SPAN = 2 * TICK_CYCLES + 8;
	localparam int SAFE_LEN = 20 * TICK_CYCLES;
	logic [31:0] al_q;
	logic [31:0] al_d;
	logic [31:0] pr_q;
	logic [31:0] pr_d;
	// cycles the alarm has been standing
	always_comb al_d = alarm_o ? al_q + 32'h0000_0001 : 32'h0000_0000;
	// cycles a reset button has been held without a break
	always_comb pr_d = (reset_local_i || reset_remote_i) ? pr_q + 32'h0000_0001 :
		32'h0000_0000;
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			al_q <= 32'h0000_0000;
			pr_q <= 32'h0000_0000;
		end
		else
		begin
			al_q <= al_d;
			pr_q <= pr_d;
		end
	end
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (reset_i);
	// shutdown reaction, trips and phase timing
	a_valves_off_alarm: assert property ($rose(alarm_o)
		|-> !main_valve_o && !igniter_o && !pilot_intermittent_o) else $error("valves on at alarm");
	a_alarm_led_lit: assert property ($rose(alarm_o) |-> ##[0:LED_HI] led_alarm_o)
		else $error("alarm led not lit");
	a_flame_loss_trip: assert property (main_valve_o && !flame_i |-> ##[1:6] alarm_o)
		else $error("no trip on flame loss");
	a_air_open_trip: assert property (main_valve_o && !air_flow_proving_switch_i
		|-> ##[1:6] alarm_o) else $error("no trip on air open");
	a_interlock_trip: assert property (main_valve_o && !interlock_closed_i
		|-> ##[1:6] (alarm_o && !main_valve_o)) else $error("no trip on interlock");
	a_ignition_outputs: assert property ($rose(igniter_o)
		|-> pilot_intermittent_o && pilot_interrupted_o && blower_o) else $error("ign outputs");
	a_main_trial_len: assert property ($rose(main_valve_o) && !direct_main_ignition_i
		|-> ##MT_LO pilot_interrupted_o ##[1:MT_SPAN] !pilot_interrupted_o)
		else $error("main trial length");
	a_direct_main_run: assert property ($rose(main_valve_o) && direct_main_ignition_i
		|-> !pilot_interrupted_o && !igniter_o) else $error("direct main trial seen");
	a_start_clean: assert property ($rose(blower_o) |-> !$past(flame_i, 2)
		&& $past(interlock_closed_i, 2) && !$past(air_flow_proving_switch_i, 2))
		else $error("unclean start");
	a_safety_hold: assert property (al_q != 0 && al_q < SAFE_LEN |-> alarm_o)
		else $error("alarm cleared in safety time");
	a_reset_hold: assert property ($fell(alarm_o) |-> $past(pr_q, 2) >= HOLD_CYCLES)
		else $error("short reset accepted");
	c_trip: cover property ($rose(alarm_o));
	c_direct: cover property ($rose(main_valve_o) && direct_main_ignition_i);
	c_cleared: cover property ($fell(alarm_o));
endmodule : bslc_checker

bind bslc_top bslc_checker #(.TICK_CYCLES(TICK_CYCLES), .HOLD_CYCLES(HOLD_CYCLES)) u_checker (
	.clk_i(clk_i), .reset_i(reset_i), .air_flow_proving_switch_i(air_flow_proving_switch_i),
	.flame_i(flame_i), .interlock_closed_i(interlock_closed_i),
	.direct_main_ignition_i(direct_main_ignition_i), .reset_local_i(reset_local_i),
	.reset_remote_i(reset_remote_i), .blower_o(blower_o), .igniter_o(igniter_o),
	.pilot_intermittent_o(pilot_intermittent_o), .pilot_interrupted_o(pilot_interrupted_o),
	.main_valve_o(main_valve_o), .alarm_o(alarm_o), .led_alarm_o(led_alarm_o));

//--- verification/bslc_field_model.sv
// field side model: air proving switch and flame sensor answering the outputs
`timescale 1ns/1ns
module bslc_field_model (
	input wire logic clk_i,
	input wire logic blower_i,
	input wire logic igniter_i,
	input wire logic pilot_i,
	input wire logic main_i,
	input wire logic no_flame_i,
	input wire logic air_fail_i,
	input wire logic stray_flame_i,
	output logic air_o,
	output logic flame_o
);
	logic [3:0] dly_q = 4'h3;
	initial air_o = 1'h0;
	// air switch follows the blower after a random spin-up or run-down time
	always @(posedge clk_i)
	begin
		if (air_o == (blower_i && !air_fail_i))
			dly_q <= 4'($urandom_range(12, 3));
		else if (dly_q == 4'h0)
			air_o <= !air_o;
		else
			dly_q <= dly_q - 4'h1;
	end
	// flame burns while fuel flows, unless the bench starves it; a stray source also shows
	assign flame_o = stray_flame_i || ((igniter_i || pilot_i || main_i) && !no_flame_i);
endmodule : bslc_field_model

//--- verification/bslc_tb_top.sv
// self-checking testbench for the burner sequence lockout controller
`timescale 1ns/1ns
module bslc_tb_top;
	localparam int T = 20;
	localparam int H = 50;
	logic clk_i = 1'h0, reset_i = 1'h1, demand = 1'h0, ilock = 1'h1, dmi = 1'h0, b;
	logic rl = 1'h0, rr = 1'h0, restore = 1'h0, wr_i = 1'h0, rd_i = 1'h0;
	logic no_flame = 1'h0, air_fail = 1'h0, stray = 1'h0, air, flame;
	logic blower, ign, pint, pintr, mv, alarm, ledf, leda, lstore;
	logic [3:0] addr_i = 4'h0;
	logic [31:0] wdata_i = 32'h0000_0000, rdata_o, d;
	int err_total = 0, num_checks = 0, n, i, k;
	bslc_top #(.TICK_CYCLES(T), .HOLD_CYCLES(H)) DUT (.clk_i(clk_i), .reset_i(reset_i),
		.heat_demand_i(demand), .air_flow_proving_switch_i(air), .flame_i(flame),
		.interlock_closed_i(ilock), .direct_main_ignition_i(dmi), .reset_local_i(rl),
		.reset_remote_i(rr), .lock_restore_i(restore), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .blower_o(blower), .igniter_o(ign),
		.pilot_intermittent_o(pint), .pilot_interrupted_o(pintr), .main_valve_o(mv),
		.alarm_o(alarm), .led_flame_o(ledf), .led_alarm_o(leda), .lock_store_o(lstore));
	bslc_field_model FIELD (.clk_i(clk_i), .blower_i(blower), .igniter_i(ign), .pilot_i(pint),
		.main_i(mv), .no_flame_i(no_flame), .air_fail_i(air_fail), .stray_flame_i(stray),
		.air_o(air), .flame_o(flame));
	// 50 ns system clock
	initial
	begin
		forever #25 clk_i = ~clk_i;
	end
	// phase of s ticks, measured in cycles, allowing tick alignment and pipeline
	function automatic logic in_span(input int n, input int s);
		return n >= s * T && n <= (s + 2) * T + 6;
	endfunction : in_span
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e)
		begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic rd(input logic [3:0] a);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'h1;
		@(posedge clk_i);
		rd_i <= 1'h0;
		@(negedge clk_i);
		d = rdata_o;
	endtask : rd
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= v;
		wr_i <= 1'h1;
		@(posedge clk_i);
		wr_i <= 1'h0;
	endtask : wr
	task automatic wait_st(input logic [3:0] s, input int lim);
		int j;
		for (j = 0; j < lim && d[3:0] !== s; j++)
			rd(bslc_pkg::ADDR_STATUS);
		chk("state", {28'h000_0000, s}, {28'h000_0000, d[3:0]});
		d = 32'h0000_0000;
	endtask : wait_st
	task automatic press(input logic rem, input int len);
		@(posedge clk_i);
		rl <= !rem;
		rr <= rem;
		repeat (len) @(posedge clk_i);
		rl <= 1'h0;
		rr <= 1'h0;
		@(negedge clk_i);
	endtask : press
	// clear every fault, reset locally and return to standby
	task automatic recover();
		wait_st(bslc_pkg::ST_LOCKOUT, 400);
		no_flame <= 1'h0;
		air_fail <= 1'h0;
		stray <= 1'h0;
		ilock <= 1'h1;
		press(1'h0, H + 6);
		chk("alarm_clear", 1'h0, alarm);
		rd(bslc_pkg::ADDR_STATUS);
		chk("restart", 1'h0, d[3:0] === bslc_pkg::ST_LOCKOUT);
		demand <= 1'h0;
		wait_st(bslc_pkg::ST_STANDBY, 300);
	endtask : recover
	task automatic tally_and_finish();
		if (err_total == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : tally_and_finish
	// hang guard
	initial
	begin
		repeat (80000) @(posedge clk_i);
		err_total++;
		tally_and_finish();
	end
	// main sequence
	initial
	begin
		void'($urandom(44));
		repeat (3) @(posedge clk_i);
		reset_i <= 1'h0;
		repeat (5) @(negedge clk_i);
		b = ledf;
		repeat (T) @(negedge clk_i);
		chk("blink", 1'h1, {b, ledf} === 2'h1 || {b, ledf} === 2'h2);
		rd(bslc_pkg::ADDR_CTRL);
		chk("ctrl_reset", 32'h0000_0000, d);
		wr(bslc_pkg::ADDR_STATUS, 32'hffff_ffff);
		rd(4'hc);
		chk("unmapped", 32'h0000_0000, d);
		wait_st(bslc_pkg::ST_STANDBY, 100);
		// normal cycle with phase lengths
		demand <= 1'h1;
		for (n = 0; n < 5000 && air !== 1'h1; n++) @(negedge clk_i);
		for (n = 0; n < 5000 && ign !== 1'h1; n++) @(negedge clk_i);
		chk("purge", 1'h1, in_span(n, 37));
		for (n = 0; n < 5000 && ign === 1'h1; n++) @(negedge clk_i);
		chk("ign_len", 1'h1, in_span(n, bslc_pkg::IGN_STD_S));
		wait_st(bslc_pkg::ST_RUN, 400);
		chk("run_valves", 2'h2, {mv, pintr});
		for (k = 0; k < 2; k++)
		begin
			demand <= 1'h0;
			wait_st(bslc_pkg::ST_STANDBY, 300);
			chk("blower_off", 1'h0, blower);
			dmi <= (k == 0);
			demand <= (k == 0);
			if (k == 0)
				wait_st(bslc_pkg::ST_RUN, 1500);
			if (k == 0)
				chk("direct_run", 3'h4, {mv, ign, pintr});
		end
		// faults in run: flame loss, air open, interlock open
		for (k = 0; k < 3; k++)
		begin
			demand <= 1'h1;
			wait_st(bslc_pkg::ST_RUN, 1500);
			no_flame <= (k == 0);
			air_fail <= (k == 1);
			ilock <= (k != 2);
			wait_st(bslc_pkg::ST_SAFETY, 20);
			chk("trip", 2'h2, {alarm, mv});
			press(1'h0, H + 6);
			rd(bslc_pkg::ADDR_STATUS);
			chk("held", {1'h1, 4'hd}, {d[5], d[3:0]});
			wait_st(bslc_pkg::ST_LOCKOUT, 400);
			rd(bslc_pkg::ADDR_STATUS);
			chk("lock_flags", {k == 0, 2'h3}, {d[6], d[4], lstore});
			press(1'h0, H - 5);
			chk("short_press", 1'h1, alarm);
			if (k == 2)
				press(1'h0, H + 6);
			if (k == 2)
				wait_st(bslc_pkg::ST_SAFETY, 20);
			recover();
		end
		// ignition failure, standard then retry model
		for (k = 0; k < 2; k++)
		begin
			wr(bslc_pkg::ADDR_CTRL, k);
			rd(bslc_pkg::ADDR_CTRL);
			chk("ctrl", k, d);
			no_flame <= 1'h1;
			demand <= 1'h1;
			for (i = 0; i <= k; i++)
			begin
				for (n = 0; n < 5000 && ign !== 1'h1; n++) @(negedge clk_i);
				for (n = 0; n < 5000 && ign === 1'h1; n++) @(negedge clk_i);
				chk("trial", 1'h1, in_span(n, k ? 10 : 3));
			end
			wait_st(bslc_pkg::ST_SAFETY, 20);
			recover();
		end
		wr(bslc_pkg::ADDR_CTRL, 32'h0000_0000);
		// stray flame in standby, remote reset rate limit
		for (k = 0; k < 6; k++)
		begin
			stray <= 1'h1;
			wait_st(bslc_pkg::ST_SAFETY, 20);
			stray <= 1'h0;
			wait_st(bslc_pkg::ST_LOCKOUT, 400);
			press(1'h1, H + 6 + $urandom_range(9));
			chk("remote", k == 5, alarm);
		end
		rd(bslc_pkg::ADDR_STATUS);
		chk("remote_used", 3'h5, d[10:8]);
		recover();
		// lockout restored across a power cycle
		restore <= 1'h1;
		reset_i <= 1'h1;
		repeat (3) @(posedge clk_i);
		reset_i <= 1'h0;
		wait_st(bslc_pkg::ST_LOCKOUT, 100);
		chk("restored", 2'h3, {alarm, lstore});
		restore <= 1'h0;
		repeat (20 * T) @(posedge clk_i);
		recover();
		tally_and_finish();
	end
endmodule : bslc_tb_top
